// ===== inc/ade_pkg.sv
`default_nettype none
package ade_pkg;
	// register byte addresses
	localparam logic [7:0] ADE_OFF_ENT_LO = 8'h00;
	localparam logic [7:0] ADE_OFF_ENT_HI = 8'h04;
	localparam logic [7:0] ADE_OFF_UID_LO = 8'h08;
	localparam logic [7:0] ADE_OFF_UID_HI = 8'h0c;
	localparam logic [7:0] ADE_OFF_CTRL = 8'h10;
	localparam logic [7:0] ADE_OFF_STATUS = 8'h14;
	localparam logic [7:0] ADE_OFF_DECODE = 8'h18;
	// control bit positions
	localparam int ADE_CTRL_SVC = 0;
	localparam int ADE_CTRL_CFG = 2;
	localparam int ADE_CTRL_GO = 3;
	localparam int ADE_CTRL_EXPL = 4;
	// status bit positions
	localparam int ADE_ST_OK = 3;
	localparam int ADE_ST_BUSY = 4;
	localparam int ADE_ST_TMO = 8;
	localparam int ADE_ST_REF = 9;
	localparam int ADE_ST_DUP = 10;
	localparam int ADE_ST_LEFT = 12;
	// reset values
	localparam logic [7:0] ADE_ENT_RST = 8'h00;
	localparam logic [47:0] ADE_UID_RST = 48'h0;
	// first-byte format codes, and the loopback mark of byte one
	localparam logic [7:0] ADE_UNUSED_OR_LOOPBACK_CODE = 8'h00;
	localparam logic [7:0] ADE_UNICAST_CODE = 8'h01;
	localparam logic [7:0] ADE_UNIQUE_IDENTIFIER_FORMAT_CODE = 8'h02;
	localparam logic [7:0] ADE_BCAST_CODE = 8'h03;
	localparam logic [7:0] ADE_LOOP_MARK = 8'h01;
	// group limits and broadcast default backlog
	localparam logic [6:0] ADE_GRP_MIN = 7'h02;
	localparam logic [6:0] ADE_GRP_MAX = 7'h40;
	localparam logic [6:0] ADE_MEMB_MAX = 7'h3f;
	localparam logic [5:0] ADE_BL_DEF = 6'h0f;
	// timing: interval bases in ms, receive window is eight times longer
	localparam logic [14:0] ADE_BASE_EVEN_MS = 15'h0010;
	localparam logic [14:0] ADE_BASE_ODD_MS = 15'h0018;
	localparam int ADE_RCV_SHIFT = 3;
	localparam int ADE_CLK_NS = 50;
	localparam int ADE_MS_NS = 1000000;
	localparam int ADE_MS_CYC = ADE_MS_NS / ADE_CLK_NS;
	// axi responses
	localparam logic [1:0] ADE_RESP_OK = 2'h0;
	localparam logic [1:0] ADE_RESP_DEC = 2'h3;

	typedef enum logic [2:0] {
		FMT_UNUSED, FMT_LOOP, FMT_UNI, FMT_UID, FMT_BCAST, FMT_GROUP, FMT_BAD
	} ade_fmt_t;
	typedef enum logic [1:0] {SVC_ACKD, SVC_RPT, SVC_UNACKD, SVC_REQRESP} ade_svc_t;
	typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT} ade_st_t;

	typedef struct packed {
		ade_fmt_t fmt;
		logic ok;
		logic domain;
		logic [6:0] id7;
		logic unlimited;
		logic [5:0] backlog;
		logic [7:0] dest8;
		logic all_nodes;
		logic [3:0] rpt;
		logic [3:0] retry;
		logic [3:0] rcv;
		logic [3:0] tx;
	} ade_dec_t;

	typedef struct packed {
		logic grp;
		logic [3:0] tid;
		logic uid;
		logic domain;
	} ade_rx_t;
endpackage : ade_pkg
`default_nettype wire

// ===== hdl/ade_decoder.sv
// Summary of operation
// - top bit of byte zero selects group
// - group size field counts two to 64
// - size zero: unlimited, no acknowledged service
// - member number 0..63, unlimited uses zero
// - one bit picks domain entry 0/1
// - code 1: unicast node and subnet
// - unicast node zero is invalid
// - unicast subnet zero is invalid
// - code 3: broadcast with backlog, subnet
// - backlog zero means fifteen
// - broadcast subnet zero reaches whole domain
// - broadcast completes on first acknowledgement
// - code 0: loopback if byte one is 1
// - code 2: unique identifier, explicit only
// - unconfigured node answers on arrival domain
// - identifier subnet zero passes all routers
// - at most retry field plus one copies, unacknowledged sends one
// - repeat interval from 16 to 3072 ms
// - receive window eight times receive field interval
// - same transaction within window is duplicate
// - retry interval uses repeat mapping
// - retry timer restarts on attempt, ack
// - first-byte code ranges select format
`default_nettype none
module ade_decoder #(
	parameter int unsigned TICK_CYCLES = ade_pkg::ADE_MS_CYC
) (
	input wire logic sys_clk, // system clock
	input wire logic rst_n, // synchronous reset
	input wire logic ce, // clock enable
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic ack_in, // acknowledgement or response received
	input wire logic ack_final, // it is the last one expected
	input wire ade_pkg::ade_rx_t rx, // received message event
	output logic tx_attempt, // send one copy now
	output logic tx_done, // transaction over
	output logic tx_timeout, // retries exhausted
	output logic rx_dup, // duplicate group message
	output logic flex_reply, // reply with zero source ids
	output logic reply_domain, // domain to reply on
	output ade_pkg::ade_dec_t dec // decoded entry
);
	import ade_pkg::*;

	// interval code to ms: base 16 or 24, doubled per code pair
	function automatic logic [14:0] ade_ivl(input logic [3:0] code);
		logic [14:0] base;
		base = code[0] ? ADE_BASE_ODD_MS : ADE_BASE_EVEN_MS;
		return base << code[3:1];
	endfunction : ade_ivl

	// byte-lane merge for strobed writes
	function automatic logic [31:0] ade_merge(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return res;
	endfunction : ade_merge

	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

	logic [7:0] ent [0:4];
	logic [47:0] uid;
	ade_svc_t svc;
	logic configured;
	logic explicit_mode;
	logic aw_hold;
	logic w_hold;
	logic [7:0] aw_q;
	logic [31:0] wd_q;
	logic [3:0] ws_q;
	logic wr_fire;
	logic go;
	ade_svc_t go_svc;
	logic acked;
	logic refuse;
	logic st_tmo;
	logic st_ref;
	logic st_dup;
	ade_st_t state;
	logic [4:0] left;
	logic [14:0] ms_left;
	logic [14:0] cur_ivl;
	logic cur_bc;
	logic cur_ack;
	logic cur_rpt;
	logic [15:0] tick_cnt;
	logic tick;
	logic [14:0] win_left;
	logic [3:0] last_tid;
	ade_dec_t next_dec;
	logic [31:0] rd_word;
	logic [1:0] rd_resp;
	logic [31:0] ent_lo;

	// write channels taken independently, response after both
	assign s_axi_awready = ce && !aw_hold && !s_axi_bvalid; // no handshake while frozen
	assign s_axi_wready = ce && !w_hold && !s_axi_bvalid;
	assign s_axi_arready = ce && !s_axi_rvalid;
	assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;
	assign go = wr_fire && aw_q == ADE_OFF_CTRL && ws_q[0] && wd_q[ADE_CTRL_GO];
	// the service written together with go governs the new transaction
	assign go_svc = ade_svc_t'(wd_q[ADE_CTRL_SVC +: 2]);
	assign acked = go_svc == SVC_ACKD || go_svc == SVC_REQRESP;
	assign refuse = go && (state != ST_IDLE || !dec.ok || (acked && dec.unlimited));
	assign tick = tick_cnt == TICK_LAST;
	assign ent_lo = {ent[3], ent[2], ent[1], ent[0]};

	// write address/data capture and response
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_q <= 8'h00;
			wd_q <= 32'h0;
			ws_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ADE_RESP_OK;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				aw_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				wd_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_q == ADE_OFF_ENT_LO || aw_q == ADE_OFF_ENT_HI ||
						aw_q == ADE_OFF_UID_LO || aw_q == ADE_OFF_UID_HI ||
						aw_q == ADE_OFF_CTRL || aw_q == ADE_OFF_STATUS ||
						aw_q == ADE_OFF_DECODE) begin
					s_axi_bresp <= ADE_RESP_OK;
				end else begin
					s_axi_bresp <= ADE_RESP_DEC;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// entry bytes, identifier and control fields
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 5; i++) begin
				ent[i] <= ADE_ENT_RST;
			end
			uid <= ADE_UID_RST;
			svc <= SVC_ACKD;
			configured <= 1'b0;
			explicit_mode <= 1'b0;
		end else if (ce && wr_fire) begin
			if (aw_q == ADE_OFF_ENT_LO) begin
				{ent[3], ent[2], ent[1], ent[0]} <= ade_merge(ent_lo, wd_q, ws_q);
			end else if (aw_q == ADE_OFF_ENT_HI) begin
				if (ws_q[0]) begin
					ent[4] <= wd_q[7:0];
				end
			end else if (aw_q == ADE_OFF_UID_LO) begin
				uid[31:0] <= ade_merge(uid[31:0], wd_q, ws_q);
			end else if (aw_q == ADE_OFF_UID_HI) begin
				if (ws_q[0]) begin
					uid[39:32] <= wd_q[7:0];
				end
				if (ws_q[1]) begin
					uid[47:40] <= wd_q[15:8];
				end
			end else if (aw_q == ADE_OFF_CTRL && ws_q[0]) begin
				svc <= ade_svc_t'(wd_q[ADE_CTRL_SVC +: 2]);
				configured <= wd_q[ADE_CTRL_CFG];
				explicit_mode <= wd_q[ADE_CTRL_EXPL];
			end
		end
	end

	// entry decode by first-byte code
	always_comb begin
		next_dec = '0;
		next_dec.rpt = ent[2][7:4];
		next_dec.retry = ent[2][3:0];
		next_dec.rcv = ent[3][7:4];
		next_dec.tx = ent[3][3:0];
		next_dec.domain = ent[1][7];
		next_dec.dest8 = ent[4];
		next_dec.fmt = FMT_BAD;
		if (ent[0][7]) begin
			next_dec.fmt = FMT_GROUP;
			next_dec.id7 = ent[1][6:0];
			next_dec.unlimited = ent[0][6:0] == 7'h00;
			if (next_dec.unlimited) begin
				next_dec.ok = ent[1][6:0] == 7'h00;
			end else begin
				next_dec.ok = ent[0][6:0] >= ADE_GRP_MIN && ent[0][6:0] <= ADE_GRP_MAX &&
					ent[1][6:0] <= ADE_MEMB_MAX;
			end
		end else if (ent[0] == ADE_UNICAST_CODE) begin
			next_dec.fmt = FMT_UNI;
			next_dec.id7 = ent[1][6:0];
			next_dec.ok = ent[1][6:0] != 7'h00 && ent[4] != 8'h00;
		end else if (ent[0] == ADE_BCAST_CODE) begin
			next_dec.fmt = FMT_BCAST;
			next_dec.backlog = ent[1][5:0] == 6'h00 ? ADE_BL_DEF : ent[1][5:0];
			next_dec.all_nodes = ent[4] == 8'h00;
			next_dec.ok = 1'b1;
		end else if (ent[0] == ADE_UNIQUE_IDENTIFIER_FORMAT_CODE) begin
			next_dec.fmt = FMT_UID;
			next_dec.all_nodes = ent[4] == 8'h00;
			next_dec.ok = explicit_mode;
		end else if (ent[0] == ADE_UNUSED_OR_LOOPBACK_CODE) begin
			if (ent[1] == ADE_LOOP_MARK) begin
				next_dec.fmt = FMT_LOOP;
				next_dec.ok = 1'b1;
			end else if (ent[1] == 8'h00) begin
				next_dec.fmt = FMT_UNUSED;
			end
		end
	end

	// decoded entry register
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			dec <= '0;
		end else if (ce) begin
			dec <= next_dec;
		end
	end

	// millisecond tick from the system clock
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			tick_cnt <= 16'h0000;
		end else if (ce) begin
			tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
		end
	end

	// transaction sequencer: attempts, retry timer, completion
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			left <= 5'h00;
			ms_left <= 15'h0000;
			cur_ivl <= 15'h0000;
			cur_bc <= 1'b0;
			cur_ack <= 1'b0;
			cur_rpt <= 1'b0;
			tx_attempt <= 1'b0;
			tx_done <= 1'b0;
			tx_timeout <= 1'b0;
		end else if (ce) begin
			tx_attempt <= 1'b0;
			tx_done <= 1'b0;
			tx_timeout <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (go && !refuse) begin
						left <= {1'b0, dec.retry} + 5'h01;
						cur_ivl <= acked ? ade_ivl(dec.tx) : ade_ivl(dec.rpt);
						cur_bc <= dec.fmt == FMT_BCAST;
						cur_ack <= acked;
						cur_rpt <= go_svc == SVC_RPT;
						state <= ST_SEND;
					end
				end
				ST_SEND: begin
					tx_attempt <= 1'b1;
					left <= left - 5'h01;
					ms_left <= cur_ivl;
					if (!cur_ack && (!cur_rpt || left == 5'h01)) begin
						tx_done <= 1'b1;
						state <= ST_IDLE;
					end else begin
						state <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (cur_ack && ack_in) begin
						if (ack_final || cur_bc) begin
							tx_done <= 1'b1;
							state <= ST_IDLE;
						end else begin
							ms_left <= cur_ivl;
						end
					end else if (tick) begin
						if (ms_left == 15'h0001) begin
							if (left != 5'h00) begin
								state <= ST_SEND;
							end else begin
								tx_timeout <= cur_ack;
								tx_done <= 1'b1;
								state <= ST_IDLE;
							end
						end else begin
							ms_left <= ms_left - 15'h0001;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// group receive window and duplicate detection, flexible domain reply
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			win_left <= 15'h0000;
			last_tid <= 4'h0;
			rx_dup <= 1'b0;
			flex_reply <= 1'b0;
			reply_domain <= 1'b0;
		end else if (ce) begin
			rx_dup <= 1'b0;
			flex_reply <= rx.uid && !configured;
			if (rx.uid) begin
				reply_domain <= rx.domain;
			end
			if (rx.grp) begin
				if (win_left != 15'h0000 && rx.tid == last_tid) begin
					rx_dup <= 1'b1;
				end else begin
					win_left <= ade_ivl(dec.rcv) << ADE_RCV_SHIFT;
					last_tid <= rx.tid;
				end
			end else if (tick && win_left != 15'h0000) begin
				win_left <= win_left - 15'h0001;
			end
		end
	end

	// sticky status flags, set wins over write-one-to-clear
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_tmo <= 1'b0;
			st_ref <= 1'b0;
			st_dup <= 1'b0;
		end else if (ce) begin
			if (tx_timeout) begin
				st_tmo <= 1'b1;
			end else if (wr_fire && aw_q == ADE_OFF_STATUS && wd_q[ADE_ST_TMO] && ws_q[1]) begin
				st_tmo <= 1'b0;
			end
			if (refuse) begin
				st_ref <= 1'b1;
			end else if (wr_fire && aw_q == ADE_OFF_STATUS && wd_q[ADE_ST_REF] && ws_q[1]) begin
				st_ref <= 1'b0;
			end
			if (rx_dup) begin
				st_dup <= 1'b1;
			end else if (wr_fire && aw_q == ADE_OFF_STATUS && wd_q[ADE_ST_DUP] && ws_q[1]) begin
				st_dup <= 1'b0;
			end
		end
	end

	// read word selection
	always_comb begin
		rd_word = 32'h0;
		rd_resp = ADE_RESP_OK;
		if (s_axi_araddr == ADE_OFF_ENT_LO) begin
			rd_word = ent_lo;
		end else if (s_axi_araddr == ADE_OFF_ENT_HI) begin
			rd_word = {24'h0, ent[4]};
		end else if (s_axi_araddr == ADE_OFF_UID_LO) begin
			rd_word = uid[31:0];
		end else if (s_axi_araddr == ADE_OFF_UID_HI) begin
			rd_word = {16'h0, uid[47:32]};
		end else if (s_axi_araddr == ADE_OFF_CTRL) begin
			rd_word[ADE_CTRL_SVC +: 2] = svc;
			rd_word[ADE_CTRL_CFG] = configured;
			rd_word[ADE_CTRL_EXPL] = explicit_mode;
		end else if (s_axi_araddr == ADE_OFF_STATUS) begin
			rd_word[2:0] = dec.fmt;
			rd_word[ADE_ST_OK] = dec.ok;
			rd_word[ADE_ST_BUSY] = state != ST_IDLE;
			rd_word[ADE_ST_TMO] = st_tmo;
			rd_word[ADE_ST_REF] = st_ref;
			rd_word[ADE_ST_DUP] = st_dup;
			rd_word[ADE_ST_LEFT +: 5] = left;
		end else if (s_axi_araddr == ADE_OFF_DECODE) begin
			rd_word = {6'h00, dec.unlimited, dec.all_nodes, dec.dest8, 2'h0, dec.backlog,
				dec.id7, dec.domain};
		end else begin
			rd_resp = ADE_RESP_DEC;
		end
	end

	// read channel
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= ADE_RESP_OK;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_resp;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// helper: copies sent in the current transaction
	logic [4:0] sent;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sent <= 5'h00;
		end else if (ce) begin
			if (state == ST_IDLE) begin
				sent <= 5'h00;
			end else if (tx_attempt) begin
				sent <= sent + 5'h01;
			end
		end
	end

	grp_fmt_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ent[0][7] |-> next_dec.fmt == FMT_GROUP)
		else $error("top bit set but not decoded as group");
	grp_size_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ent[0][7] && ent[0][6:0] > ADE_GRP_MAX |-> !next_dec.ok)
		else $error("oversize group accepted");
	unlim_ack_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ce && state == ST_IDLE && go && acked && dec.unlimited |=> state == ST_IDLE && st_ref)
		else $error("acknowledged service started on unlimited group");
	uni_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ent[0] == ADE_UNICAST_CODE && (ent[1][6:0] == 7'h00 || ent[4] == 8'h00) |-> !next_dec.ok)
		else $error("unicast entry with zero node or subnet accepted");
	bl_def_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ent[0] == ADE_BCAST_CODE && ent[1][5:0] == 6'h00 |-> next_dec.backlog == 6'h0f)
		else $error("broadcast default backlog not fifteen");
	send_cnt_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state != ST_IDLE |-> sent <= {1'b0, dec.retry} + 5'h01)
		else $error("more copies sent than retry plus one");
	rpt_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ce && state == ST_SEND && cur_rpt |=> ms_left == cur_ivl && tx_attempt)
		else $error("repeat timer not loaded on attempt");
	dup_seen_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ce && rx.grp && win_left != 15'h0000 && rx.tid == last_tid |=> rx_dup ##1 st_dup)
		else $error("duplicate inside window not flagged");
	bc_first_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ce && state == ST_WAIT && cur_ack && cur_bc && ack_in |=> state == ST_IDLE && tx_done)
		else $error("broadcast did not end on first answer");
	tmo_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ce && tx_timeout |=> st_tmo)
		else $error("timeout not latched");
endmodule : ade_decoder
`default_nettype wire

// ===== sim/ade_peer_model.sv
`default_nettype none
module ade_peer_model #(
	parameter int DELAY = 40
) (
	input wire logic sys_clk, // system clock
	input wire logic rst_n, // synchronous reset
	input wire logic tx_attempt, // copy sent by the block
	input wire logic [1:0] mode, // 0 silent, 1 first answer not final, 2 final
	output logic ack_in, // answer pulse
	output logic ack_final // last-answer qualifier
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt;
	logic nans;
	// answer each copy after a fixed turnaround; qualifier is garbage between answers
	always_ff @(posedge sys_clk) begin
		if (!rst_n || mode == 2'h0) begin
			cnt <= 8'h0;
			nans <= 1'b0;
			ack_in <= 1'b0;
			ack_final <= 1'b0;
		end else begin
			ack_in <= cnt == 8'h1;
			ack_final <= (cnt == 8'h1) ? (mode == 2'h2 || nans) : !ack_final;
			if (tx_attempt)
				cnt <= 8'(DELAY);
			else if (cnt != 8'h0)
				cnt <= cnt - 8'h1;
			if (cnt == 8'h1)
				nans <= 1'b1;
		end
	end
endmodule : ade_peer_model
`default_nettype wire

// ===== sim/address_entry_timer_decoder_test.sv
`default_nettype none
module address_entry_timer_decoder_test;
	timeunit 1ns;
	timeprecision 1ns;
	import ade_pkg::*;
	localparam int T = 4;
	localparam int MS [16] = '{16, 24, 32, 48, 64, 96, 128, 192, 256, 384, 512, 768, 1024,
		1536, 2048, 3072};
	localparam logic [7:0] SZ [8] = '{8'h0, 8'h1, 8'h2, 8'h40, 8'h41, 8'h0, 8'h7f, 8'h3};
	localparam logic [7:0] MK [4] = '{8'h80, 8'hbf, 8'hff, 8'hff};
	logic sys_clk, rst_n, ce, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr, b0, b1, b4;
	logic [31:0] wdata, rdata, rnd, rv, dv, dm;
	logic [3:0] wstrb, st;
	logic [1:0] bresp, rresp, rs, p_mode;
	logic ack_in, ack_final, tx_attempt, tx_done, tx_timeout, rx_dup, flex_reply, reply_domain;
	ade_rx_t rx;
	ade_dec_t dec;
	int mismatches, n_compared, cyc, n_done, n_tmo, n_dup, n_flex, i;
	int att_q[$];

	ade_decoder #(.TICK_CYCLES(T)) ade_decoder_inst (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ack_in(ack_in), .ack_final(ack_final), .rx(rx), .tx_attempt(tx_attempt),
		.tx_done(tx_done), .tx_timeout(tx_timeout), .rx_dup(rx_dup), .flex_reply(flex_reply),
		.reply_domain(reply_domain), .dec(dec));
	ade_peer_model #(.DELAY(40)) ade_peer_model_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.tx_attempt(tx_attempt), .mode(p_mode), .ack_in(ack_in), .ack_final(ack_final));

	// clock
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// event monitor, sampled mid-cycle
	always @(negedge sys_clk) begin
		cyc++;
		if (rst_n && tx_attempt === 1'b1) att_q.push_back(cyc);
		if (rst_n && tx_done === 1'b1) n_done++;
		if (rst_n && tx_timeout === 1'b1) n_tmo++;
		if (rst_n && rx_dup === 1'b1) n_dup++;
		if (rst_n && flex_reply === 1'b1) n_flex++;
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction : xs

	// expected status nibble, decode word and the decode bits that matter
	function automatic void exp_dec(input logic [7:0] a, b, c, input logic ex,
		output logic [3:0] s, output logic [31:0] v, m);
		v = {6'h0, a[6:0] == 7'h0, c == 8'h0, c, 2'h0, (b[5:0] == 6'h0) ? 6'h0f : b[5:0],
			b[6:0], b[7]};
		m = 32'h0;
		s = 4'h6;
		if (a[7]) begin
			s = {(a[6:0] == 7'h0) ? b[6:0] == 7'h0 : (a[6:0] >= 7'h2 && a[6:0] <= 7'h40 &&
				b[6:0] <= 7'h3f), 3'h5};
			m = 32'h02ff00ff;
		end else if (a == 8'h01) begin
			s = {b[6:0] != 7'h0 && c != 8'h0, 3'h2};
			m = 32'h00ff00ff;
		end else if (a == 8'h03) begin
			s = 4'hc;
			m = 32'h01ff3f01;
		end else if (a == 8'h00) begin
			s = (b == 8'h01) ? 4'h9 : 4'h0;
		end else if (a == 8'h02) begin
			s = {ex, 3'h3};
			m = 32'h01ff0001;
		end
	endfunction : exp_dec

	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask : chk

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic ha, hw, got;
		got = 1'b0;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!got) begin
			@(negedge sys_clk);
			ha = awvalid && awready;
			hw = wvalid && wready;
			got = bvalid;
			rs = bresp;
			@(posedge sys_clk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		@(posedge sys_clk);
		chk("write answered", 1, {31'h0, got && !bvalid});
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a);
		logic ha, got;
		got = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!got) begin
			@(negedge sys_clk);
			ha = arvalid && arready;
			got = rvalid;
			rv = rdata;
			rs = rresp;
			@(posedge sys_clk);
			if (ha) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		@(posedge sys_clk);
		chk("read answered", 1, {31'h0, got && !rvalid});
	endtask : axi_rd

	// one transaction: entry, go, then count copies, spacing and timeouts
	task automatic run_tx(input logic [7:0] a, input logic [3:0] rp, rt, tx,
		input logic [1:0] svc, md, input int na, tm, gap);
		int n, g;
		axi_wr(ADE_OFF_ENT_LO, {4'h0, tx, rp, rt, a[7] ? 8'h00 : 8'h05, a});
		axi_wr(ADE_OFF_ENT_HI, 32'h7);
		p_mode <= md;
		att_q.delete();
		n_done = 0;
		n_tmo = 0;
		axi_wr(ADE_OFF_CTRL, {28'h0, 2'h3, svc});
		for (n = 0; n < 30000 && n_done == 0 && na != 0; n++)
			@(posedge sys_clk);
		repeat (3 * T + 4) @(posedge sys_clk);
		p_mode <= 2'h0;
		chk("copies", na, att_q.size());
		chk("timeouts", tm, n_tmo);
		chk("done", (na != 0) ? 1 : 0, n_done);
		for (n = 1; n < att_q.size(); n++) begin
			g = att_q[n] - att_q[n - 1];
			chk("copy gap", gap, (g >= gap - T && g <= gap + T + 6) ? gap : g);
		end
		$display("transaction test done");
	endtask : run_tx

	task automatic rxp(input logic g, u, d, input logic [3:0] t);
		rx <= '{grp: g, tid: t, uid: u, domain: d};
		@(posedge sys_clk);
		rx <= '{grp: 1'b0, tid: t, uid: 1'b0, domain: d};
		@(posedge sys_clk);
	endtask : rxp

	// watchdog
	initial begin
		repeat (60000) @(posedge sys_clk);
		mismatches++;
		test_done();
	end

	initial begin
		rnd = 32'hf82916b2;
		{rst_n, awvalid, wvalid, bready, arvalid, rready, p_mode} = '0;
		{awaddr, araddr, wdata} = '0;
		ce = 1'b1;
		wstrb = 4'hf;
		rx = '0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		axi_rd(ADE_OFF_STATUS);
		chk("status reset", 32'h0, rv);
		axi_rd(ADE_OFF_ENT_LO);
		chk("entry reset", 32'h0, rv);
		axi_rd(8'h1c);
		chk("unmapped read", ADE_RESP_DEC, rs);
		axi_wr(8'h20, 32'h0);
		chk("unmapped write", ADE_RESP_DEC, rs);
		axi_wr(ADE_OFF_UID_HI, 32'habcd1234);
		axi_rd(ADE_OFF_UID_HI);
		chk("identifier high", 32'h00001234, rv);
		$display("register test done");
		// random entries of every format, corner sizes and zero fields among them
		for (i = 0; i < 60; i++) begin
			rnd = xs(rnd);
			b0 = 8'h80 | {1'b0, rnd[14:8]};
			b1 = rnd[23:16] & MK[rnd[25:24]];
			b4 = (rnd[29:28] == 2'h0) ? 8'h0 : rnd[31:24];
			case (rnd[2:0])
				3'h1: b0 = 8'h80 | SZ[rnd[10:8]];
				3'h2, 3'h7: b0 = 8'h01;
				3'h3: b0 = 8'h03;
				3'h4: b0 = 8'h00;
				3'h5: b0 = 8'h02;
				3'h6: b0 = {1'b0, rnd[14:8]} | 8'h04;
				default: ;
			endcase
			if (b0 == 8'h00) b1 = {7'h0, rnd[16]};
			exp_dec(b0, b1, b4, rnd[3], st, dv, dm);
			axi_wr(ADE_OFF_CTRL, {27'h0, rnd[3], 4'h4});
			axi_wr(ADE_OFF_ENT_LO, {rnd[15:0], b1, b0});
			axi_wr(ADE_OFF_ENT_HI, {24'h0, b4});
			axi_rd(ADE_OFF_STATUS);
			chk("format", {28'h0, st}, rv & 32'hf);
			chk("dec format", {29'h0, st[2:0]}, {29'h0, dec.fmt});
			axi_rd(ADE_OFF_DECODE);
			chk("decode", dv & dm, rv & dm);
		end
		$display("decode test done");
		// repeated service over interval codes 0 to 5, last one on an unlimited group
		for (i = 0; i < 6; i++)
			run_tx((i == 5) ? 8'h80 : 8'h01, i[3:0], 4'((i % 3) + 1), 4'h0, 2'h1, 2'h0,
				(i % 3) + 2, 0, MS[i] * T);
		run_tx(8'h01, 4'h0, 4'h2, 4'h1, 2'h0, 2'h0, 3, 1, MS[1] * T);
		run_tx(8'h01, 4'h0, 4'h3, 4'h0, 2'h0, 2'h1, 2, 0, 40 + MS[0] * T);
		run_tx(8'h03, 4'h0, 4'h3, 4'h0, 2'h3, 2'h1, 1, 0, 0);
		run_tx(8'h01, 4'h0, 4'h2, 4'h0, 2'h3, 2'h2, 1, 0, 0);
		run_tx(8'h01, 4'h0, 4'h3, 4'h0, 2'h2, 2'h0, 1, 0, 0);
		run_tx(8'h80, 4'h0, 4'h1, 4'h0, 2'h0, 2'h0, 0, 0, 0);
		axi_rd(ADE_OFF_STATUS);
		chk("refused", 1, rv[ADE_ST_REF]);
		axi_wr(ADE_OFF_STATUS, 32'h200);
		axi_rd(ADE_OFF_STATUS);
		chk("refused cleared", 0, rv[ADE_ST_REF]);
		// receive window of code 1, duplicate just inside, fresh just outside
		axi_wr(ADE_OFF_ENT_LO, 32'h10000581);
		n_dup = 0;
		rxp(1'b1, 1'b0, 1'b0, 4'h6);
		repeat (98) @(posedge sys_clk);
		rxp(1'b1, 1'b0, 1'b0, 4'h6);
		rxp(1'b1, 1'b0, 1'b0, 4'h9);
		repeat (8 * MS[1] * T - 3 * T - 2) @(posedge sys_clk);
		rxp(1'b1, 1'b0, 1'b0, 4'h9);
		repeat (6 * T - 2) @(posedge sys_clk);
		rxp(1'b1, 1'b0, 1'b0, 4'h9);
		repeat (4) @(posedge sys_clk);
		chk("duplicates", 2, n_dup);
		$display("receive test done");
		// unique-identifier message while unconfigured, then configured
		axi_wr(ADE_OFF_CTRL, 32'h0);
		n_flex = 0;
		rxp(1'b0, 1'b1, 1'b1, 4'h0);
		chk("reply domain", 1, reply_domain);
		axi_wr(ADE_OFF_CTRL, 32'h4);
		rxp(1'b0, 1'b1, 1'b0, 4'h0);
		repeat (3) @(posedge sys_clk);
		chk("flexible replies", 1, n_flex);
		// clock enable low: a message must leave reply_domain and flex_reply as they were
		axi_wr(ADE_OFF_CTRL, 32'h0);
		ce <= 1'b0;
		rxp(1'b0, 1'b1, 1'b1, 4'h0);
		ce <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk("frozen domain", 0, reply_domain);
		chk("frozen flex", 1, n_flex);
		$display("identifier test done");
		test_done();
	end
endmodule : address_entry_timer_decoder_test
`default_nettype wire
